// *** reset_restore_pkg.sv ***
// Constants and carrier types for the delayed reset and restore trigger.
package reset_restore_pkg;

    localparam logic [15:0] COUNTDOWN_ADDR = 16'h1037;
    localparam logic [15:0] SELECT_ADDR = 16'h1038;
    localparam logic [15:0] COUNTDOWN_RESET = 16'h0000;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [15:0] COUNTDOWN_MAX = 16'h00FF;
    localparam logic [15:0] SELECT_REBOOT = 16'h0000;
    localparam logic [15:0] SELECT_RESTORE = 16'h0001;
    localparam logic [7:0] SERVER_ID_DEFAULT = 8'hC8;

    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

    typedef struct packed {
        logic [7:0] unit;
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic [15:0] rdata;
    } reg_rsp_t;

endpackage

// *** io_board_reset_restore_trigger.sv ***
// Delayed reset and restore trigger reached through holding-register accesses.
`timescale 1ns/1ps
`default_nettype none
module io_board_reset_restore_trigger
    import reset_restore_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire reg_req_t req_i,
    output var reg_rsp_t rsp_o,
    output logic restore_defaults_o,
    output logic reboot_o,
    output logic [7:0] countdown_o
);

    // Last prescaler count of one tick.
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES_P - 1);

    // Tick prescaler state.
    logic [31:0] presc_r;
    logic [31:0] presc_nxt;

    // Register file state.
    logic [15:0] countdown_r;
    logic [15:0] countdown_nxt;
    logic [15:0] select_r;
    logic [15:0] select_nxt;

    // Response state.
    reg_rsp_t rsp_r;
    reg_rsp_t rsp_nxt;

    // Action pulse state.
    logic restore_r;
    logic restore_nxt;
    logic reboot_r;
    logic reboot_nxt;

    // Decoded request terms.
    logic hit;
    logic wr_take;
    logic rd_take;
    logic at_countdown;
    logic at_select;
    logic countdown_ok;
    logic select_ok;
    logic countdown_load;
    logic select_load;

    // Timing terms.
    logic tick;
    logic running;
    logic expire;

    // Requests for other server addresses belong to other boards on the line.
    // server address match
    assign hit = (req_i.unit == SERVER_ID_DEFAULT);

    assign wr_take = hit && req_i.wr;

    // A write wins when a faulty client raises both strobes at once.
    assign rd_take = hit && req_i.rd && !req_i.wr;

    assign at_countdown = (req_i.addr == COUNTDOWN_ADDR);
    assign at_select = (req_i.addr == SELECT_ADDR);

    assign countdown_ok = (req_i.wdata <= COUNTDOWN_MAX);

    assign select_ok = (req_i.wdata <= SELECT_RESTORE);

    // Out-of-range values are refused whole rather than truncated.
    assign countdown_load = wr_take && at_countdown && countdown_ok;
    assign select_load = wr_take && at_select && select_ok;

    assign tick = (presc_r == TICK_LAST);
    assign running = (countdown_r != COUNTDOWN_RESET);

    // Only the tick on which the count is one fires, so a written zero never acts.
    // zero never triggers
    assign expire = tick && (countdown_r == 16'h0001);

    // Tick prescaler: one tick every TICK_CYCLES_P clocks.
    // 100 ms tick base
    always_comb begin
        presc_nxt = presc_r + 32'h00000001;
        if (countdown_load) begin
            // A fresh load starts a whole tick, so the first unit is never short.
            presc_nxt = 32'h00000000;
        end else if (tick) begin
            presc_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            presc_r <= 32'h00000000;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // Countdown register.
    always_comb begin
        countdown_nxt = countdown_r;
        if (countdown_load) begin
            countdown_nxt = req_i.wdata;
        end else if (running && tick) begin
            countdown_nxt = countdown_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            countdown_r <= COUNTDOWN_RESET;
        end else begin
            countdown_r <= countdown_nxt;
        end
    end

    // Selector register; a change during a countdown is used at expiry.
    always_comb begin
        select_nxt = select_r;
        if (select_load) begin
            select_nxt = req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            select_r <= SELECT_RESET;
        end else begin
            select_r <= select_nxt;
        end
    end

    // Response to every access addressed to this board.
    always_comb begin
        rsp_nxt = '0;
        if (wr_take) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.ok = countdown_load || select_load;
        end else if (rd_take) begin
            rsp_nxt.valid = 1'b1;
            if (at_countdown) begin
                rsp_nxt.ok = 1'b1;
                rsp_nxt.rdata = countdown_r;
            end else if (at_select) begin
                rsp_nxt.ok = 1'b1;
                rsp_nxt.rdata = select_r;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // Action pulses last one clock; the receiver must latch them.
    always_comb begin
        restore_nxt = expire && (select_r == SELECT_RESTORE);
        reboot_nxt = expire && (select_r == SELECT_REBOOT);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            restore_r <= 1'b0;
            reboot_r <= 1'b0;
        end else begin
            restore_r <= restore_nxt;
            reboot_r <= reboot_nxt;
        end
    end

    // All outputs come straight from flip-flops.
    assign rsp_o = rsp_r;
    assign restore_defaults_o = restore_r;
    assign reboot_o = reboot_r;

    // Values are capped at 255, so the low byte carries the whole count.
    assign countdown_o = countdown_r[7:0];

    // The tick base depends on the clock: retune TICK_CYCLES_P for another clock.
    // A write landing on the expiry tick still fires the pending action.

endmodule
`default_nettype wire

// *** reset_restore_checker.sv ***
// Port assertions for the reset and restore trigger.
`timescale 1ns/1ps
`default_nettype none
module reset_restore_checker import reset_restore_pkg::*; #(parameter int TICK_CYCLES_P = 4) (
    input wire logic clk_i, input wire logic rstn_i, input wire reg_req_t req_i,
    input wire reg_rsp_t rsp_o, input wire logic restore_defaults_o, input wire logic reboot_o,
    input wire logic [7:0] countdown_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence take_s; req_i.unit == 8'hC8 && (req_i.wr || req_i.rd); endsequence
    wire cw = req_i.wr && req_i.addr == COUNTDOWN_ADDR;
    chk_answer_next: assert property (take_s |=> rsp_o.valid) else $error("no answer");
    chk_foreign_unit: assert property (req_i.unit != 8'hC8 |=> !rsp_o.valid) else $error("foreign");
    chk_load_count: assert property (take_s ##0 cw && req_i.wdata <= 16'h00FF |=> countdown_o == $past(req_i.wdata)) else $error("load");
    chk_count_range: assert property (take_s ##0 cw && req_i.wdata > 16'h00FF |=> !rsp_o.ok) else $error("range");
    chk_sel_range: assert property (take_s ##0 req_i.wr && req_i.addr == SELECT_ADDR && req_i.wdata > 16'h0001 |=> !rsp_o.ok) else $error("sel");
    chk_restore_expiry: assert property (restore_defaults_o |-> countdown_o == 8'h00 && $past(countdown_o) == 8'h01) else $error("restore");
    chk_reboot_expiry: assert property (reboot_o |-> !restore_defaults_o && $past(countdown_o) == 8'h01) else $error("reboot");
    chk_zero_quiet: assert property ($past(countdown_o) == 8'h00 |-> !(reboot_o || restore_defaults_o)) else $error("zero");
endmodule
bind io_board_reset_restore_trigger reset_restore_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.clk_i, .rstn_i, .req_i, .rsp_o, .restore_defaults_o, .reboot_o, .countdown_o);
`default_nettype wire

// *** modbus_client_model.sv ***
// Register client that issues one access per call.
`timescale 1ns/1ps
`default_nettype none
module modbus_client_model import reset_restore_pkg::*; (
    input wire logic clk_i,
    output var reg_req_t req_o
);
    initial req_o = '0;
    task automatic acc(input logic w, input logic [15:0] a, d, input logic [7:0] u);
        @(posedge clk_i) req_o <= '{unit:u, wr:w, rd:!w, addr:a, wdata:d};
        @(posedge clk_i) req_o <= '0;
    endtask
endmodule
`default_nettype wire

// *** io_board_reset_restore_trigger_tb.sv ***
// Self-checking bench for the reset and restore trigger.
`timescale 1ns/1ps
`default_nettype none
module io_board_reset_restore_trigger_tb;
    import reset_restore_pkg::*;
    logic clk_i = 0, rstn_i = 0, restore_defaults_o, reboot_o;
    reg_req_t req_i;
    reg_rsp_t rsp_o;
    logic [7:0] countdown_o;
    logic [18:0] q[$];
    int num_errors = 0, checked = 0, cyc = 0, seed = 1, v;
    initial forever #5 clk_i = ~clk_i;
    io_board_reset_restore_trigger #(.TICK_CYCLES_P(4)) u_io_board_reset_restore_trigger (.clk_i, .rstn_i, .req_i, .rsp_o, .restore_defaults_o, .reboot_o, .countdown_o);
    modbus_client_model u_modbus_client_model (.clk_i, .req_o(req_i));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t(logic w, logic [15:0] a, d, logic [7:0] u, logic [18:0] e);
        if (u == 8'hC8) q.push_back(e);
        u_modbus_client_model.acc(w, a, d, u);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rstn_i && (rsp_o.valid !== 1'b0 || restore_defaults_o !== 1'b0 || reboot_o !== 1'b0)) begin
            checked++;
            if ({restore_defaults_o, reboot_o, rsp_o.ok, rsp_o.rdata} !== q[0]) begin
                num_errors++;
                $display("ERROR outputs exp %h got %h", q[0], {restore_defaults_o, reboot_o, rsp_o.ok, rsp_o.rdata});
            end
            if (q.size() > 0) void'(q.pop_front());
        end
        if (cyc > 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1;
        t(0, COUNTDOWN_ADDR, 0, 8'hC8, 19'h10000);
        t(1, SELECT_ADDR, 1, 8'hC8, 19'h10000);
        t(1, COUNTDOWN_ADDR, 10, 8'hC8, 19'h10000);
        q.push_back(19'h40000);
        repeat (40) @(posedge clk_i);
        #1;
        checked++;
        if (restore_defaults_o !== 1'b1 || countdown_o !== 8'h00) begin
            num_errors++;
            $display("ERROR restore_timing exp 1 got %b", restore_defaults_o);
        end
        repeat (5) @(posedge clk_i);
        $display("restore test done");
        v = 1 + {$random(seed)} % 8;
        t(1, SELECT_ADDR, 0, 8'hC8, 19'h10000);
        t(1, COUNTDOWN_ADDR, 16'(v), 8'hC8, 19'h10000);
        q.push_back(19'h20000);
        repeat (40) @(posedge clk_i);
        $display("reboot test done");
        t(1, COUNTDOWN_ADDR, 16'h0100, 8'hC8, 0);
        t(1, SELECT_ADDR, 16'h0002, 8'hC8, 0);
        t(0, 16'h1039, 0, 8'hC8, 0);
        t(1, SELECT_ADDR, 1, 8'h01, 0);
        t(0, SELECT_ADDR, 0, 8'hC8, 19'h10000);
        $display("refusal test done");
        t(1, COUNTDOWN_ADDR, 8, 8'hC8, 19'h10000);
        t(1, COUNTDOWN_ADDR, 0, 8'hC8, 19'h10000);
        repeat (40) @(posedge clk_i);
        $display("cancel test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
